// File: sim/port_peer.sv
// far-side serial port model: offers queued bytes over valid/ready
module port_peer (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // byte handshake toward the block
    input wire logic ready_i,
    output logic valid_o,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] tx_q[$];

    // idle data flips every cycle so a stale byte never looks steady
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            valid_o <= 1'b0;
            data_o <= 8'h00;
        end else begin
            if (valid_o && ready_i) begin
                void'(tx_q.pop_front());
            end
            if (tx_q.size() != 0) begin
                valid_o <= 1'b1;
                data_o <= tx_q[0];
            end else begin
                valid_o <= 1'b0;
                data_o <= ~data_o;
            end
        end
    end
endmodule

// File: sim/tb_transparent_escape_detector.sv
// self-checking bench for the transparent escape detector
`include "tm_consts.svh"

module tb_transparent_escape_detector;
    timeunit 1ns;
    timeprecision 1ps;
    import tm_pkg::*;

    localparam int HALF = 20;
    localparam int LIMIT = 6000;

    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic start_i = 1'b0;
    logic answer_valid_i = 1'b0;
    logic answer_yes_i = 1'b0;
    logic entry_valid_i = 1'b0;
    logic [7:0] entry_char_i = 8'h00;
    logic loc_valid_i, rem_valid_i, loc_ready_o, rem_ready_o;
    logic [7:0] loc_data_i, rem_data_i, to_rem_data_o, to_loc_data_o;
    logic to_rem_valid_o, to_loc_valid_o, transparent_transfer_mode_o, exit_pulse_o;
    logic ctrl_chars_en_o, local_flow_en_o, remote_flow_en_o;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    int exits = 0;
    logic [7:0] exp_rem[$];
    logic [7:0] exp_loc[$];

    // rows: receive answer, transmit answer, expected local and remote flow enables
    logic [3:0] rows [4] = '{4'h3, 4'h5, 4'ha, 4'hc};

    always #2 clk_sys_i = ~clk_sys_i;

    transparent_escape_detector #(.ESC_MAX(32), .HALF_CYCLES(HALF)) i_dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .start_i(start_i),
        .answer_valid_i(answer_valid_i), .answer_yes_i(answer_yes_i),
        .entry_valid_i(entry_valid_i), .entry_char_i(entry_char_i),
        .loc_valid_i(loc_valid_i), .loc_data_i(loc_data_i), .loc_ready_o(loc_ready_o),
        .rem_valid_i(rem_valid_i), .rem_data_i(rem_data_i), .rem_ready_o(rem_ready_o),
        .to_rem_valid_o(to_rem_valid_o), .to_rem_data_o(to_rem_data_o),
        .to_loc_valid_o(to_loc_valid_o), .to_loc_data_o(to_loc_data_o),
        .transparent_transfer_mode_o(transparent_transfer_mode_o),
        .exit_pulse_o(exit_pulse_o), .ctrl_chars_en_o(ctrl_chars_en_o),
        .local_flow_en_o(local_flow_en_o), .remote_flow_en_o(remote_flow_en_o));

    port_peer i_loc_peer (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ready_i(loc_ready_o),
        .valid_o(loc_valid_i), .data_o(loc_data_i));
    port_peer i_rem_peer (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ready_i(rem_ready_o),
        .valid_o(rem_valid_i), .data_o(rem_data_i));

    // ==========================================
    // comparisons and closing
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // output monitor; an unexpected byte counts against the design
    always @(posedge clk_sys_i) begin
        cycles++;
        if (exit_pulse_o === 1'b1) begin
            exits++;
        end
        if (to_rem_valid_o === 1'b1) begin
            if (exp_rem.size() == 0) begin
                chk_bit(1'b1, 1'b0, "unexpected byte toward remote");
            end else begin
                chk_byte(to_rem_data_o, exp_rem.pop_front(), "toward remote");
            end
        end
        if (to_loc_valid_o === 1'b1) begin
            if (exp_loc.size() == 0) begin
                chk_bit(1'b1, 1'b0, "unexpected byte toward local");
            end else begin
                chk_byte(to_loc_data_o, exp_loc.pop_front(), "toward local");
            end
        end
        if (cycles == LIMIT) begin
            chk_bit(1'b0, 1'b1, "run too long");
            stop_test();
        end
    end

    // ==========================================
    // stimulus tasks
    task automatic setup(input logic rx, input logic tx, input logic [7:0] esc[$]);
        @(posedge clk_sys_i) start_i <= 1'b1;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        answer_valid_i <= 1'b1;
        answer_yes_i <= rx;
        @(posedge clk_sys_i) answer_yes_i <= tx;
        @(posedge clk_sys_i) answer_valid_i <= 1'b0;
        foreach (esc[i]) begin
            entry_valid_i <= 1'b1;
            entry_char_i <= esc[i];
            @(posedge clk_sys_i);
        end
        entry_valid_i <= 1'b1;
        entry_char_i <= `TM_CR;
        @(posedge clk_sys_i) entry_valid_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        chk_bit(transparent_transfer_mode_o, 1'b1, "mode not entered");
        chk_bit(ctrl_chars_en_o, 1'b0, "control chars still active");
    endtask

    task automatic send(input logic from_rem, input logic [7:0] b, input logic seen);
        @(negedge clk_sys_i);
        if (from_rem) begin
            i_rem_peer.tx_q.push_back(b);
            if (seen) exp_loc.push_back(b);
        end else begin
            i_loc_peer.tx_q.push_back(b);
            if (seen) exp_rem.push_back(b);
        end
    endtask

    task automatic drain();
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_sys_i);
            if (i_loc_peer.tx_q.size() + i_rem_peer.tx_q.size() == 0 &&
                exp_rem.size() + exp_loc.size() == 0) break;
        end
        repeat (4) @(posedge clk_sys_i);
        chk_bit(exp_rem.size() + exp_loc.size() == 0, 1'b1, "bytes not delivered");
    endtask

    task automatic expect_exit(input int early);
        int n;
        n = exits;
        repeat (early) @(posedge clk_sys_i);
        chk_bit(exits == n, 1'b1, "left mode too early");
        for (int i = 0; i < 3 * HALF + 40 && exits == n; i++) @(posedge clk_sys_i);
        chk_bit(exits == n + 1, 1'b1, "no single exit pulse");
        repeat (3) @(posedge clk_sys_i);
        chk_bit(transparent_transfer_mode_o, 1'b0, "mode kept after exit");
        chk_bit(ctrl_chars_en_o, 1'b1, "control chars not back");
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        chk_bit(transparent_transfer_mode_o, 1'b0, "mode after reset");
        chk_bit(ctrl_chars_en_o & local_flow_en_o & remote_flow_en_o, 1'b1, "enables at reset");
        chk_bit(loc_ready_o | rem_ready_o, 1'b0, "ready outside mode");
        // quiet-only sequence of two commas, once per answer pair
        foreach (rows[r]) begin
            setup(rows[r][3], rows[r][2], {`TM_COMMA, `TM_COMMA});
            chk_bit(local_flow_en_o, rows[r][1], "local flow enable");
            chk_bit(remote_flow_en_o, rows[r][0], "remote flow enable");
            expect_exit(HALF + 2);
            repeat (4) @(posedge clk_sys_i);
        end
        setup(1'b0, 1'b0, {8'h61, 8'h62});
        // flow and control characters both ways, all eight bits
        send(1'b0, 8'h11, 1'b1);
        send(1'b0, 8'hff, 1'b1);
        send(1'b1, 8'h13, 1'b1);
        send(1'b1, 8'h80, 1'b1);
        send(1'b0, 8'h01, 1'b1);
        drain();
        // partial match held, then released with its breaker
        // a character-only match may only start after a second of quiet
        repeat (2 * HALF + 6) @(posedge clk_sys_i);
        send(1'b0, 8'h61, 1'b0);
        repeat (12) @(posedge clk_sys_i);
        exp_rem.push_back(8'h61);
        send(1'b0, 8'h78, 1'b1);
        drain();
        // no leading quiet here, so the first character is not held
        send(1'b1, 8'h61, 1'b1);
        send(1'b1, 8'h79, 1'b1);
        drain();
        // full match from the remote side after a second of quiet
        repeat (2 * HALF + 6) @(posedge clk_sys_i);
        send(1'b1, 8'h61, 1'b0);
        send(1'b1, 8'h62, 1'b0);
        expect_exit(2 * HALF - 4);
        stop_test();
    end
endmodule

// File: verilog/tm_consts.svh
// timing, character and sizing constants for the transparent escape detector
`ifndef TM_CONSTS_SVH
`define TM_CONSTS_SVH

`define TM_ESC_MAX 32
`define TM_CR 8'h0d
`define TM_COMMA 8'h2c
`define TM_CLK_NS 4
`define TM_QUIET_MS 500
`define TM_NS_PER_MS 1000000
`define TM_PRE_HALVES 6'h02
`define TM_HALVES_MAX 6'h3f
`define TM_DIR_LOC 1'b0
`define TM_DIR_REM 1'b1

`endif

// File: verilog/tm_pkg.sv
// types shared by the transparent escape detector
package tm_pkg;

    typedef struct packed {
        logic       quiet;
        logic [7:0] ch;
    } esc_entry_s;

    typedef struct packed {
        logic       dir;
        logic [7:0] data;
    } tm_char_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ASK_RX,
        ST_ASK_TX,
        ST_ENTRY,
        ST_ACTIVE,
        ST_RELEASE
    } tm_state_e;

endpackage

// File: verilog/transparent_escape_detector.sv
// transparent transfer path with escape sequence detection
// Notes on behaviour
// - eight-bit characters pass unchanged both ways
// - binary transmit: local port ignores XON/XOFF
// - binary receive: remote port ignores XON/XOFF
// - control characters forwarded as data; escape only
// - one-way binary keeps other side flow control
// - both directions binary disables all inband flow
// - escape store holds 32 entries, commas included, CR excluded
// - carriage return ends entry, starts transparent mode
// - comma is half-second quiet; commas add up
// - quiet-only sequence ends mode on idle line
// - matcher watches both directions
// - partly matching characters are held back
// - mismatch releases held characters then breaker
// - character sequence needs one second quiet around
// - full match returns to control, link kept
// - setup asks receive, transmit, then escape sequence

`include "tm_consts.svh"

module transparent_escape_detector
    import tm_pkg::*;
#(
    parameter int ESC_MAX = `TM_ESC_MAX,
    parameter int HALF_CYCLES = (`TM_QUIET_MS * `TM_NS_PER_MS) / `TM_CLK_NS
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // setup dialogue
    input wire logic start_i,
    input wire logic answer_valid_i,
    input wire logic answer_yes_i,
    input wire logic entry_valid_i,
    input wire logic [7:0] entry_char_i,
    // characters arriving from the local and remote ports
    input wire logic loc_valid_i,
    input wire logic [7:0] loc_data_i,
    output logic loc_ready_o,
    input wire logic rem_valid_i,
    input wire logic [7:0] rem_data_i,
    output logic rem_ready_o,
    // characters leaving toward remote and local ports
    output logic to_rem_valid_o,
    output logic [7:0] to_rem_data_o,
    output logic to_loc_valid_o,
    output logic [7:0] to_loc_data_o,
    // mode status
    output logic transparent_transfer_mode_o,
    output logic exit_pulse_o,
    output logic ctrl_chars_en_o,
    output logic local_flow_en_o,
    output logic remote_flow_en_o
);

    localparam int IW = $clog2(ESC_MAX + 2);
    localparam int SW = $clog2(HALF_CYCLES + 1);
    localparam logic [IW-1:0] ESC_MAX_W = IW'(ESC_MAX);
    localparam logic [SW-1:0] HALF_LAST = SW'(HALF_CYCLES - 1);

    // ==========================================================
    // state
    tm_state_e state_q, state_d;
    logic recv_bin_q, xmit_bin_q;
    esc_entry_s esc_q [ESC_MAX];
    logic [IW-1:0] len_q, idx_q, idx_d;
    logic char_only_q;
    tm_char_s hold_q [ESC_MAX+1];
    logic [IW-1:0] hcnt_q, hcnt_d, rptr_q;
    logic [SW-1:0] sub_q;
    logic [5:0] halves_q, need_q;
    logic turn_q, loc_rdy_q, rem_rdy_q;
    logic to_rem_valid_q, to_loc_valid_q;
    logic [7:0] to_rem_data_q, to_loc_data_q;
    logic active_q, exit_q, ctrl_en_q, lflow_q, rflow_q;

    // ==========================================================
    // decoding
    wire loc_fire = loc_valid_i & loc_rdy_q;
    wire rem_fire = rem_valid_i & rem_rdy_q;
    // one port is taken per cycle, so the matcher sees one ordered stream
    wire fire = loc_fire | rem_fire;
    wire tm_char_s cur = loc_fire ? {`TM_DIR_LOC, loc_data_i} : {`TM_DIR_REM, rem_data_i};
    wire in_active = (state_q == ST_ACTIVE);
    wire in_release = (state_q == ST_RELEASE);
    wire in_seq = (idx_q < len_q);
    wire esc_entry_s ent = in_seq ? esc_q[idx_q[IW-2:0]] : '0;
    // a character-only sequence only starts after a second of quiet
    wire start_ok = !char_only_q || (idx_q != '0) || (halves_q >= `TM_PRE_HALVES);
    wire hit = in_active & fire & in_seq & !ent.quiet & (ent.ch == cur.data) & start_ok;
    wire miss = in_active & fire & !hit;
    wire pass_now = miss & (hcnt_q == '0);
    wire flush = miss & (hcnt_q != '0);
    wire quiet_step = in_active & !fire & in_seq & ent.quiet & (halves_q > need_q);
    wire post_ok = !char_only_q || (halves_q >= `TM_PRE_HALVES);
    wire done_now = in_active & !fire & (len_q != '0) & (idx_q == len_q) & post_ok;
    wire rel_last = in_release & (rptr_q == hcnt_q - IW'(1));
    wire is_cr = (entry_char_i == `TM_CR);
    wire is_comma = (entry_char_i == `TM_COMMA);
    wire in_entry = (state_q == ST_ENTRY);
    wire ent_end = in_entry & entry_valid_i & is_cr;
    wire ent_we = in_entry & entry_valid_i & !is_cr & (len_q < ESC_MAX_W);
    wire push = hit | flush;
    wire tm_char_s rel_c = hold_q[rptr_q];
    wire out_v = in_release | pass_now;
    wire tm_char_s out_c = in_release ? rel_c : cur;
    wire act_d = (state_d == ST_ACTIVE) || (state_d == ST_RELEASE);

    // ==========================================================
    // control sequence
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_i) begin
                    state_d = ST_ASK_RX;
                end
            end
            ST_ASK_RX: begin
                if (answer_valid_i) begin
                    state_d = ST_ASK_TX;
                end
            end
            ST_ASK_TX: begin
                if (answer_valid_i) begin
                    state_d = ST_ENTRY;
                end
            end
            ST_ENTRY: begin
                if (ent_end) begin
                    state_d = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (flush) begin
                    state_d = ST_RELEASE;
                end else if (done_now) begin
                    state_d = ST_IDLE;
                end
            end
            ST_RELEASE: begin
                if (rel_last) begin
                    state_d = ST_ACTIVE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end
    always_comb begin
        idx_d = idx_q;
        if (ent_end || done_now || miss) begin
            idx_d = '0;
        end else if (hit || quiet_step) begin
            idx_d = idx_q + IW'(1);
        end
    end
    always_comb begin
        hcnt_d = hcnt_q;
        if (ent_end || done_now || rel_last) begin
            hcnt_d = '0;
        end else if (push) begin
            hcnt_d = hcnt_q + IW'(1);
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            idx_q <= '0;
            hcnt_q <= '0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            hcnt_q <= hcnt_d;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rptr_q <= '0;
        end else if (in_release && !rel_last) begin
            rptr_q <= rptr_q + IW'(1);
        end else begin
            rptr_q <= '0;
        end
    end

    // ==========================================================
    // setup answers and escape store
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            recv_bin_q <= 1'b0;
            xmit_bin_q <= 1'b0;
        end else if (answer_valid_i && state_q == ST_ASK_RX) begin
            recv_bin_q <= answer_yes_i;
        end else if (answer_valid_i && state_q == ST_ASK_TX) begin
            xmit_bin_q <= answer_yes_i;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            len_q <= '0;
            char_only_q <= 1'b1;
        end else if (start_i && state_q == ST_IDLE) begin
            len_q <= '0;
            char_only_q <= 1'b1;
        end else if (ent_we) begin
            len_q <= len_q + IW'(1);
            char_only_q <= char_only_q & !is_comma;
        end
    end
    for (genvar i = 0; i < ESC_MAX; i++) begin : g_esc
        always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i) begin
                esc_q[i] <= '0;
            end else if (ent_we && len_q == IW'(i)) begin
                // each comma is its own half-second element
                esc_q[i] <= {is_comma, is_comma ? 8'h00 : entry_char_i};
            end
        end
    end
    // held characters keep their direction for in-order release
    for (genvar i = 0; i <= ESC_MAX; i++) begin : g_hold
        always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i) begin
                hold_q[i] <= '0;
            end else if (push && hcnt_q == IW'(i)) begin
                hold_q[i] <= cur;
            end
        end
    end

    // ==========================================================
    // quiet timing
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || fire || ent_end) begin
            sub_q <= '0;
            halves_q <= '0;
        end else if (sub_q == HALF_LAST) begin
            sub_q <= '0;
            if (halves_q != `TM_HALVES_MAX) begin
                halves_q <= halves_q + 6'h01;
            end
        end else begin
            sub_q <= sub_q + SW'(1);
        end
    end
    // consecutive quiet elements demand a growing idle time
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || fire || ent_end || done_now) begin
            need_q <= '0;
        end else if (quiet_step) begin
            need_q <= need_q + 6'h01;
        end
    end

    // ==========================================================
    // data path and status outputs
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            turn_q <= 1'b0;
            loc_rdy_q <= 1'b0;
            rem_rdy_q <= 1'b0;
        end else begin
            // alternating grant: halves peak rate, keeps the outputs flopped
            turn_q <= ~turn_q;
            loc_rdy_q <= (state_d == ST_ACTIVE) & !turn_q;
            rem_rdy_q <= (state_d == ST_ACTIVE) & turn_q;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            to_rem_valid_q <= 1'b0;
            to_loc_valid_q <= 1'b0;
            to_rem_data_q <= 8'h00;
            to_loc_data_q <= 8'h00;
        end else begin
            to_rem_valid_q <= out_v & (out_c.dir == `TM_DIR_LOC);
            to_loc_valid_q <= out_v & (out_c.dir == `TM_DIR_REM);
            to_rem_data_q <= out_c.data;
            to_loc_data_q <= out_c.data;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            active_q <= 1'b0;
            exit_q <= 1'b0;
            ctrl_en_q <= 1'b1;
            lflow_q <= 1'b1;
            rflow_q <= 1'b1;
        end else begin
            active_q <= act_d;
            exit_q <= done_now;
            ctrl_en_q <= !act_d;
            lflow_q <= !(act_d & xmit_bin_q);
            rflow_q <= !(act_d & recv_bin_q);
        end
    end
    assign loc_ready_o = loc_rdy_q;
    assign rem_ready_o = rem_rdy_q;
    assign to_rem_valid_o = to_rem_valid_q;
    assign to_loc_valid_o = to_loc_valid_q;
    assign to_rem_data_o = to_rem_data_q;
    assign to_loc_data_o = to_loc_data_q;
    assign transparent_transfer_mode_o = active_q;
    assign exit_pulse_o = exit_q;
    assign ctrl_chars_en_o = ctrl_en_q;
    assign local_flow_en_o = lflow_q;
    assign remote_flow_en_o = rflow_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_data_unchanged: assert property (pass_now && loc_fire |=>
        to_rem_valid_o && to_rem_data_o == $past(loc_data_i))
        else $error("forwarded byte altered");
    a_tx_flow_off: assert property (act_d && xmit_bin_q |=> !local_flow_en_o)
        else $error("local flow control active in binary transmit");
    a_rx_flow_off: assert property (act_d && recv_bin_q |=> !remote_flow_en_o)
        else $error("remote flow control active in binary receive");
    a_ctrl_as_data: assert property (transparent_transfer_mode_o |-> !ctrl_chars_en_o)
        else $error("control characters decoded in transparent mode");
    a_flow_kept: assert property (act_d && !xmit_bin_q && recv_bin_q |=>
        local_flow_en_o && !remote_flow_en_o)
        else $error("one-way binary flow control wrong");
    a_flow_both_off: assert property (transparent_transfer_mode_o && recv_bin_q
        && xmit_bin_q |-> !local_flow_en_o && !remote_flow_en_o)
        else $error("flow control left on with both directions binary");
    a_store_limit: assert property (len_q <= ESC_MAX_W)
        else $error("escape store overrun");
    a_cr_starts: assert property (ent_end |=> transparent_transfer_mode_o)
        else $error("carriage return did not start transparent mode");
    a_comma_quiet: assert property (ent_we && is_comma |=> !char_only_q)
        else $error("comma not stored as quiet element");
    a_grant_single: assert property (!(loc_ready_o && rem_ready_o))
        else $error("both ports granted together");
    a_hit_held: assert property (hit |=> !to_rem_valid_o && !to_loc_valid_o)
        else $error("matching character leaked");
    a_flush_first: assert property (flush |-> ##2 (to_rem_valid_o || to_loc_valid_o)
        && $past(rel_c, 1) == hold_q[0])
        else $error("held characters not released first");
    a_pre_quiet: assert property (fire && in_active && char_only_q && idx_q == '0
        && halves_q < `TM_PRE_HALVES |=> idx_q == '0)
        else $error("match started without leading quiet");
    a_exit_ctrl: assert property (done_now |=> exit_pulse_o && !transparent_transfer_mode_o
        ##1 !exit_pulse_o)
        else $error("exit not a single pulse to control");
    a_setup_order: assert property (state_q == ST_ASK_RX && answer_valid_i |=>
        state_q == ST_ASK_TX)
        else $error("setup questions out of order");
    a_quiet_restart: assert property (fire |=> halves_q == '0 && sub_q == '0)
        else $error("quiet timer not restarted");
    c_exit: cover property (done_now);
    c_flush: cover property (flush ##[1:40] rel_last);
    c_quiet_step: cover property (quiet_step && char_only_q == 1'b0);
    c_both_binary: cover property (transparent_transfer_mode_o && recv_bin_q && xmit_bin_q);

endmodule
